// ==== hdl/ppfs_pin_mux.sv ====
// pin function multiplexer for four port pins with debug and test straps
// assumes pins and peripheral signals synchronous to mclk
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "ppfs_consts.svh"

// Overview of operation
// - select field 1x00 routes O0, 1x01 O1, upward through O3.
// - hardware-controlled output drives its pin regardless of the field.
// - port7 bit2 offers GPIO, analog mux 0; feeds position 0, TDI C.
// - port8 bit4 offers GPIO, two PWM ch1 outputs; feeds TMS D, capture.
// - port8 bit3 offers GPIO, two PWM ch0 outputs; feeds TDI D, capture.
// - port7 bit0 offers GPIO, timer toggles, debug line 1, trigger input.
// - start-up debug position (0 or 2) decides whether port7 bit0 carries debug line 1.
module ppfs_pin_mux
  import ppfs_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic [7:0] regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic regWr,
  input  wire logic regRd,
  output logic [15:0] regRdData,
  input  wire logic [3:0] pinIn,
  output logic [3:0] pinOut,
  output logic [3:0] pinOe,
  input  wire logic analogMuxSelect0,
  input  wire logic pwmACh1CompOut,
  input  wire logic pwmBCh1Out,
  input  wire logic pwmACh0CompOut,
  input  wire logic pwmBCh0Out,
  input  wire logic timer3ToggleOut,
  input  wire logic timer6ToggleOut,
  input  wire logic debugLine1Out,
  input  wire logic debugLine1Oe,
  input  wire logic powerOnResetIn,
  input  wire logic debugResetIn,
  input  wire logic factoryTestEnable,
  input  wire logic [1:0] debugPinPos,
  output logic debugEnabled,
  output logic debugSysResetReq,
  output logic factoryTestMode,
  output logic [1:0] debugPosLatched,
  output logic pwmPositionIn0,
  output logic jtagDataInC,
  output logic jtagModeSelD,
  output logic pwmBCh1CaptureIn,
  output logic jtagDataInD,
  output logic pwmBCh0CaptureIn,
  output logic debugLine1In,
  output logic serviceReq2Trigger1
);

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  ppfs_sel_t selR [4];
  ppfs_alt_t dataR;
  logic [15:0] rdDataR;
  logic [3:0] pinLvlR;
  logic porPrevR;
  logic dbgEnR;
  ppfs_pos_t dbgPosR;
  logic ftestR;
  logic dbgRstReqR;

  wire logic [3:0] wrCtrl;
  wire logic wrData;
  wire logic [15:0] statusWord;
  wire logic [15:0] rdMux;

  assign wrData = regWr && (regAddr == `PPFS_OFS_DATA);
  assign statusWord = {8'h00, dbgPosR, ftestR, dbgEnR, pinLvlR};
  assign rdMux =
    (regAddr == `PPFS_OFS_CTRL0) ? {12'h000, selR[0]} :
    (regAddr == `PPFS_OFS_CTRL1) ? {12'h000, selR[1]} :
    (regAddr == `PPFS_OFS_CTRL2) ? {12'h000, selR[2]} :
    (regAddr == `PPFS_OFS_CTRL3) ? {12'h000, selR[3]} :
    (regAddr == `PPFS_OFS_DATA) ? {12'h000, dataR} :
    (regAddr == `PPFS_OFS_STATUS) ? statusWord : 16'h0000;

  // read data stand one cycle only, zero otherwise
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdDataR <= 16'h0000;
    end else begin
      rdDataR <= regRd ? rdMux : 16'h0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dataR <= `PPFS_RST_DATA;
    end else if (wrData) begin
      dataR <= regWrData[3:0];
    end
  end

  // ----------------------------------------------------------------
  // strap sampling
  // ----------------------------------------------------------------
  wire logic porRise;
  assign porRise = powerOnResetIn && !porPrevR;

  // sys_rst does not clear the debug straps: they live from power-on release
  always_ff @(posedge mclk) begin
    porPrevR <= powerOnResetIn;
    if (porRise) begin
      dbgEnR <= debugResetIn;
      dbgPosR <= debugPinPos;
    end else if (!powerOnResetIn) begin
      dbgEnR <= 1'b0;
      dbgPosR <= 2'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ftestR <= 1'b0;
      dbgRstReqR <= 1'b0;
    end else begin
      ftestR <= !factoryTestEnable;
      dbgRstReqR <= dbgEnR && !debugResetIn;
    end
  end

  // ----------------------------------------------------------------
  // output multiplexer
  // ----------------------------------------------------------------
  // per pin alternate outputs O0..O3; O3 is not offered, reads low
  wire logic [3:0] altSrc [4];
  assign altSrc[`PPFS_PIN_P72] = {1'b0, 1'b0, analogMuxSelect0,
                                  dataR[`PPFS_PIN_P72]};
  assign altSrc[`PPFS_PIN_P84] = {1'b0, pwmBCh1Out, pwmACh1CompOut,
                                  dataR[`PPFS_PIN_P84]};
  assign altSrc[`PPFS_PIN_P83] = {1'b0, pwmBCh0Out, pwmACh0CompOut,
                                  dataR[`PPFS_PIN_P83]};
  assign altSrc[`PPFS_PIN_P70] = {1'b0, timer6ToggleOut, timer3ToggleOut,
                                  dataR[`PPFS_PIN_P70]};

  wire logic hwOwnP70;
  assign hwOwnP70 = dbgEnR && ((dbgPosR == `PPFS_POS_ZERO) ||
                               (dbgPosR == `PPFS_POS_TWO));

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      wire logic selOut;
      wire logic selVal;
      wire logic hwOwn;
      assign wrCtrl[gi] = regWr && (regAddr == 8'(gi));
      assign selOut = selR[gi][`PPFS_SEL_OUT_BIT];
      assign selVal =
        altSrc[gi][selR[gi][`PPFS_SEL_IDX_HI:`PPFS_SEL_IDX_LO]];
      assign hwOwn = (gi == `PPFS_PIN_P70) && hwOwnP70;

      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          selR[gi] <= `PPFS_RST_SEL;
        end else if (wrCtrl[gi]) begin
          selR[gi] <= regWrData[3:0];
        end
      end

      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          pinOut[gi] <= 1'b0;
          pinOe[gi] <= 1'b0;
          pinLvlR[gi] <= 1'b0;
        end else begin
          pinLvlR[gi] <= pinIn[gi];
          if (hwOwn) begin
            pinOut[gi] <= debugLine1Out;
            pinOe[gi] <= debugLine1Oe;
          end else begin
            pinOut[gi] <= selOut && selVal;
            pinOe[gi] <= selOut;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // alternate inputs
  // ----------------------------------------------------------------
  // inputs follow pin level
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pwmPositionIn0 <= 1'b0;
      jtagDataInC <= 1'b0;
      jtagModeSelD <= 1'b0;
      pwmBCh1CaptureIn <= 1'b0;
      jtagDataInD <= 1'b0;
      pwmBCh0CaptureIn <= 1'b0;
      debugLine1In <= 1'b0;
      serviceReq2Trigger1 <= 1'b0;
    end else begin
      pwmPositionIn0 <= pinLvlR[`PPFS_PIN_P72];
      jtagDataInC <= pinLvlR[`PPFS_PIN_P72];
      jtagModeSelD <= pinLvlR[`PPFS_PIN_P84];
      pwmBCh1CaptureIn <= pinLvlR[`PPFS_PIN_P84];
      jtagDataInD <= pinLvlR[`PPFS_PIN_P83];
      pwmBCh0CaptureIn <= pinLvlR[`PPFS_PIN_P83];
      debugLine1In <= pinLvlR[`PPFS_PIN_P70];
      serviceReq2Trigger1 <= pinLvlR[`PPFS_PIN_P70];
    end
  end

  assign regRdData = rdDataR;
  assign debugEnabled = dbgEnR;
  assign debugSysResetReq = dbgRstReqR;
  assign factoryTestMode = ftestR;
  assign debugPosLatched = dbgPosR;

endmodule : ppfs_pin_mux

// ==== inc/ppfs_consts.svh ====
// constants of the pin function select block
// assumes inclusion by its bare name from the design files
`ifndef PPFS_CONSTS_SVH
`define PPFS_CONSTS_SVH

// register word addresses
`define PPFS_OFS_CTRL0   8'h00
`define PPFS_OFS_CTRL1   8'h01
`define PPFS_OFS_CTRL2   8'h02
`define PPFS_OFS_CTRL3   8'h03
`define PPFS_OFS_DATA    8'h04
`define PPFS_OFS_STATUS  8'h05

// output-select field layout
`define PPFS_SEL_OUT_BIT 3
`define PPFS_SEL_IDX_HI  1
`define PPFS_SEL_IDX_LO  0

// status register bit positions
`define PPFS_ST_LVL_LO   0
`define PPFS_ST_LVL_HI   3
`define PPFS_ST_DBG_EN   4
`define PPFS_ST_FTEST    5
`define PPFS_ST_POS_LO   6
`define PPFS_ST_POS_HI   7

// reset values
`define PPFS_RST_SEL     4'h0
`define PPFS_RST_DATA    4'h0

// debug pin positions that put debug line 1 on port 7 bit 0
`define PPFS_POS_ZERO    2'h0
`define PPFS_POS_TWO     2'h2

// pin indices
`define PPFS_PIN_P72     0
`define PPFS_PIN_P84     1
`define PPFS_PIN_P83     2
`define PPFS_PIN_P70     3

`endif

// ==== inc/ppfs_pkg.sv ====
// types of the pin function select block
// assumes nothing beyond the constants header
package ppfs_pkg;
  typedef logic [3:0] ppfs_sel_t;
  typedef logic [3:0] ppfs_alt_t;
  typedef logic [1:0] ppfs_pos_t;
endpackage : ppfs_pkg

// ==== test/ppfs_board_model.sv ====
// board model: pin levels seen by the pin mux
// assumes bench drives ext/extOe, no pull devices
`timescale 1ns/10ps
module ppfs_board_model (
  input wire logic mclk,
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  input wire logic [3:0] ext,
  input wire logic [3:0] extOe,
  output logic [3:0] pinIn
);
  logic flt_r = 1'b0;
  // floating lines wander so no stale level passes
  always @(posedge mclk) flt_r <= ~flt_r;
  assign pinIn = (pinOe & pinOut) | (~pinOe & extOe & ext)
    | (~pinOe & ~extOe & {4{flt_r}});
endmodule : ppfs_board_model

// ==== test/ppfs_pin_mux_properties.sv ====
// checker of pin mux input lag, hw takeover and straps
// assumes binding onto ppfs_pin_mux, one clock mclk
`timescale 1ns/10ps
module ppfs_pin_mux_properties
  import ppfs_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] pinIn,
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  input wire logic debugLine1Out,
  input wire logic debugLine1Oe,
  input wire logic powerOnResetIn,
  input wire logic debugResetIn,
  input wire logic factoryTestEnable,
  input wire logic [1:0] debugPinPos,
  input wire logic debugEnabled,
  input wire logic debugSysResetReq,
  input wire logic factoryTestMode,
  input wire logic [1:0] debugPosLatched,
  input wire logic pwmPositionIn0,
  input wire logic jtagDataInC,
  input wire logic jtagModeSelD,
  input wire logic pwmBCh1CaptureIn,
  input wire logic jtagDataInD,
  input wire logic pwmBCh0CaptureIn,
  input wire logic debugLine1In,
  input wire logic serviceReq2Trigger1
);
  // ----------------
  // helpers
  // ----------------
  // bit n: no reset n+1 edges back, lags never see reset
  logic [1:0] up_r;
  wire logic hwOwn = debugEnabled & ~debugPosLatched[0];
  always_ff @(posedge mclk) up_r <= {up_r[0], ~sys_rst};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_alt; &up_r |-> {debugLine1In, jtagDataInD, jtagModeSelD,
    pwmPositionIn0} == $past(pinIn, 2); endproperty
  a_alt: assert property (p_alt) else $error("alt lag");
  property p_alt2; &up_r |-> {serviceReq2Trigger1, pwmBCh0CaptureIn,
    pwmBCh1CaptureIn, jtagDataInC} == $past(pinIn, 2); endproperty
  a_alt2: assert property (p_alt2) else $error("alt2 lag");
  property p_hw; up_r[0] && $past(hwOwn) |-> pinOe[3] ==
    $past(debugLine1Oe) && pinOut[3] == $past(debugLine1Out); endproperty
  a_hw: assert property (p_hw) else $error("hw pin");
  property p_en; $rose(powerOnResetIn) |=>
    debugEnabled == $past(debugResetIn); endproperty
  a_en: assert property (p_en) else $error("strap en");
  property p_off; !powerOnResetIn |=> !debugEnabled; endproperty
  a_off: assert property (p_off) else $error("por clr");
  property p_pos; $rose(powerOnResetIn) |=>
    debugPosLatched == $past(debugPinPos); endproperty
  a_pos: assert property (p_pos) else $error("strap pos");
  property p_ft; up_r[0] |->
    factoryTestMode == !$past(factoryTestEnable); endproperty
  a_ft: assert property (p_ft) else $error("ftest");
  property p_dr; up_r[0] |->
    debugSysResetReq == $past(debugEnabled && !debugResetIn); endproperty
  a_dr: assert property (p_dr) else $error("dbg rst");
endmodule : ppfs_pin_mux_properties
bind ppfs_pin_mux ppfs_pin_mux_properties u_props (.*);

// ==== test/tb_port_pin_function_select.sv ====
// bench: table of select cases, then status and strap tests
// assumes board model and bound checker
`timescale 1ns/10ps
module tb_port_pin_function_select;
  import ppfs_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic debugLine1Out = 1'b0, debugLine1Oe = 1'b0, powerOnResetIn = 1'b0;
  logic debugResetIn = 1'b0, factoryTestEnable = 1'b1, debugSysResetReq;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000, regRdData;
  logic [3:0] pinIn, pinOut, pinOe, ext = 4'h5, extOe = 4'h0;
  logic [1:0] debugPinPos = 2'h1, pi;
  logic [6:0] per = 7'h00;
  // row: pin, select, peripherals, {oe, out}
  logic [19:0] rows [13];
  int n_errors = 0, total_checks = 0, cyc = 0;
  // {oe, driven level} of the pin under test in the table
  wire logic [1:0] pinPair;
  assign pinPair = {pinOe[pi], pinOut[pi] & pinOe[pi]};
  always #2.5 mclk = ~mclk;
  ppfs_pin_mux DUT (.*, .analogMuxSelect0(per[0]), .pwmACh1CompOut(per[1]),
    .pwmBCh1Out(per[2]), .pwmACh0CompOut(per[3]), .pwmBCh0Out(per[4]),
    .timer3ToggleOut(per[5]), .timer6ToggleOut(per[6]), .debugEnabled(),
    .factoryTestMode(), .debugPosLatched(), .pwmPositionIn0(),
    .jtagDataInC(), .jtagModeSelD(), .pwmBCh1CaptureIn(), .jtagDataInD(),
    .pwmBCh0CaptureIn(), .debugLine1In(), .serviceReq2Trigger1());
  ppfs_board_model u_board (.*);
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    // data stand until this edge; read before the edge moves them
    @(posedge mclk);
    chk(regRdData, e);
  endtask : rd
  task finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      finish_test;
    end
  end
  initial begin
    rows = '{20'h08002, 20'h0c7f2, 20'h09013, 20'h017f0, 20'h19023,
      20'h1a022, 20'h18003, 20'h29083, 20'h2e103, 20'h2b7f2, 20'h39203,
      20'h3a202, 20'h38003};
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    powerOnResetIn <= 1'b1;
    rd(8'h00, 16'h0000);
    chk({12'h000, pinOe}, 16'h0000);
    wr(8'h04, 16'h000a);
    $display("reset test done");
    foreach (rows[i]) begin
      pi = rows[i][17:16];
      per <= rows[i][10:4];
      wr({6'h00, pi}, {12'h000, rows[i][15:12]});
      // field lands at one edge, the pin follows at the next
      repeat (2) @(posedge mclk);
      chk({14'h0, pinPair}, {12'h0, rows[i][3:0]});
    end
    $display("table done");
    for (int k = 0; k < 4; k++) wr(8'(k), 16'h0000);
    extOe <= 4'hf;
    // last pin still driven one edge; let its level register settle
    repeat (2) @(posedge mclk);
    rd(8'h05, 16'h0045);
    rd(8'h09, 16'h0000);
    wr(8'h01, 16'hfff9);
    rd(8'h01, 16'h0009);
    factoryTestEnable <= 1'b0;
    rd(8'h05, 16'h0065);
    factoryTestEnable <= 1'b1;
    $display("status test done");
    powerOnResetIn <= 1'b0;
    debugResetIn <= 1'b1;
    debugPinPos <= 2'h2;
    repeat (2) @(posedge mclk);
    powerOnResetIn <= 1'b1;
    rd(8'h05, 16'h0095);
    debugLine1Oe <= 1'b1;
    per <= 7'h20;
    wr(8'h03, 16'h0009);
    repeat (2) @(posedge mclk);
    chk({14'h0, pinOe[3], pinOut[3]}, 16'h0002);
    debugResetIn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({15'h0, debugSysResetReq}, 16'h0001);
    // position 0 also hands the pin over; field alone would give 2
    powerOnResetIn <= 1'b0;
    debugResetIn <= 1'b1;
    debugPinPos <= 2'h0;
    debugLine1Out <= 1'b1;
    per <= 7'h00;
    repeat (2) @(posedge mclk);
    powerOnResetIn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({14'h0, pinOe[3], pinOut[3]}, 16'h0003);
    // position 1 leaves the pin to its field; debug drive would give 3
    powerOnResetIn <= 1'b0;
    debugPinPos <= 2'h1;
    repeat (2) @(posedge mclk);
    powerOnResetIn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({14'h0, pinOe[3], pinOut[3]}, 16'h0002);
    rd(8'h05, 16'h0055);
    // debug-reset driven low again after enabling
    debugResetIn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({15'h0, debugSysResetReq}, 16'h0001);
    $display("strap test done");
    finish_test;
  end
endmodule : tb_port_pin_function_select
